// File: rtl/sagc_pkg.sv
/*
  Constants for the serial address map and output-pin configuration block.
  Assumes a single 20 MHz reference clock that also stands in for the
  crystal clock.
*/
package sagc_pkg;
  // ---------------------------------------------------------------
  // Header byte layout
  // ---------------------------------------------------------------
  localparam logic [7:0] ACC_WR_SINGLE = 8'h00;
  localparam logic [7:0] ACC_WR_BURST  = 8'h40;
  localparam logic [7:0] ACC_RD_SINGLE = 8'h80;
  localparam logic [7:0] ACC_RD_BURST  = 8'hC0;
  localparam int         HDR_RW_BIT    = 7;
  localparam int         HDR_BURST_BIT = 6;

  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_PIN2_CFG   = 6'h00;
  localparam logic [5:0] ADDR_PIN1_CFG   = 6'h01;
  localparam logic [5:0] ADDR_PIN0_CFG   = 6'h02;
  localparam logic [5:0] ADDR_STROBE_LO  = 6'h30;
  localparam logic [5:0] ADDR_STROBE_HI  = 6'h3D;
  localparam logic [5:0] ADDR_PART_ID    = 6'h30;
  localparam logic [5:0] ADDR_REVISION   = 6'h31;
  localparam logic [5:0] ADDR_FREQ_EST   = 6'h32;
  localparam logic [5:0] ADDR_CHECKSUM   = 6'h33;
  localparam logic [5:0] ADDR_SIG_STR    = 6'h34;
  localparam logic [5:0] ADDR_RADIO_ST   = 6'h35;
  localparam logic [5:0] ADDR_PKT_STAT   = 6'h38;
  localparam logic [5:0] ADDR_TX_FILL    = 6'h3A;
  localparam logic [5:0] ADDR_RX_FILL    = 6'h3B;
  localparam logic [5:0] ADDR_PA_TABLE   = 6'h3E;
  localparam logic [5:0] ADDR_FIFO       = 6'h3F;

  // ---------------------------------------------------------------
  // Strobe codes
  // ---------------------------------------------------------------
  localparam logic [5:0] STROBE_CHIP_RESET = 6'h30;
  localparam logic [5:0] STROBE_SYNTH_ON   = 6'h31;
  localparam logic [5:0] STROBE_OSC_OFF    = 6'h32;
  localparam logic [5:0] STROBE_CALIBRATE  = 6'h33;
  localparam logic [5:0] STROBE_RECEIVE    = 6'h34;
  localparam logic [5:0] STROBE_TRANSMIT   = 6'h35;
  localparam logic [5:0] STROBE_GO_IDLE    = 6'h36;
  localparam logic [5:0] STROBE_POWER_DOWN = 6'h39;
  localparam logic [5:0] STROBE_FLUSH_RX   = 6'h3A;
  localparam logic [5:0] STROBE_FLUSH_TX   = 6'h3B;
  localparam logic [5:0] STROBE_NO_OP      = 6'h3D;

  // ---------------------------------------------------------------
  // Pin configuration fields and resets
  // ---------------------------------------------------------------
  localparam int         CFG_DRIVE_BIT    = 7;
  localparam int         CFG_INVERT_BIT   = 6;
  localparam int         CFG_SEL_MSB      = 5;
  localparam logic [7:0] PIN2_CFG_RESET   = 8'h29;
  localparam logic [7:0] PIN1_CFG_RESET   = 8'h2E;
  localparam logic [7:0] PIN0_CFG_RESET   = 8'h3F;
  localparam logic [7:0] PIN2_CFG_WMASK   = 8'h7F;
  localparam logic [5:0] SEL_CHIP_READY   = 6'h29;
  localparam logic [5:0] SEL_THREE_STATE  = 6'h2E;
  localparam logic [5:0] SEL_CRYSTAL_DIV  = 6'h3F;
  localparam int         CRYSTAL_DIV      = 192;
  localparam int         CRYSTAL_HALF     = CRYSTAL_DIV / 2;

  // ---------------------------------------------------------------
  // Serial transfer phases
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SAGC_IDLE   = 4'b0001,
    SAGC_HEADER = 4'b0010,
    SAGC_DATA   = 4'b0100,
    SAGC_DONE   = 4'b1000
  } sagc_phase_e;
endpackage : sagc_pkg

// File: rtl/sagc_top.sv
/*
  Serial address decoder, status readout, power table, FIFO access port and
  the three output-pin configuration registers.
  Assumes the serial pins are synchronous to ref_clk and toggle no faster
  than ref_clk/4; mode 0 framing, MSB first.
*/
// Notes on behaviour
// - Header offsets pick write/read, single/burst
// - 0x30-0x3D strobe, burst read gives status
// - Pin config survives sleep; only reset clears
// - Bit 6 inverts selected pin signal
// - Pin2 select resets to chip-ready-low
// - Pin1 bit 7 sets all pins' drive
// - Pin1 select resets to three-state
// - Pin0 select resets to crystal clock/192
// - TX fill count with underflow flag
// - RX fill count with overflow flag
`timescale 1ns/1ps
module sagc_top
  import sagc_pkg::*;
#(
  parameter logic [7:0] PART_ID   = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] REVISION  = 8'h01, // Arbitrary identity value
  parameter int         PA_DEPTH  = 8
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        csn_pin,
  input  wire logic        sclk_pin,
  input  wire logic        mosi_pin,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic [7:0]  chip_status,
  input  wire logic [7:0]  freq_offset,
  input  wire logic [7:0]  checksum_status,
  input  wire logic [7:0]  signal_level,
  input  wire logic [7:0]  radio_state,
  input  wire logic [7:0]  packet_status,
  input  wire logic [6:0]  tx_count,
  input  wire logic        tx_underflow,
  input  wire logic [6:0]  rx_count,
  input  wire logic        rx_overflow,
  input  wire logic [7:0]  rx_head_data,
  input  wire logic        sleep_active,
  input  wire logic        chip_ready_low,
  input  wire logic [63:0] pin_sources,
  output logic             strobe_pulse,
  output logic [5:0]       strobe_code,
  output logic             tx_wr_valid,
  output logic [7:0]       tx_wr_data,
  output logic             rx_rd_pulse,
  output logic             pin2_out,
  output logic             pin2_oe,
  output logic             pin1_out,
  output logic             pin1_oe,
  output logic             pin0_out,
  output logic             pin0_oe,
  output logic             output_drive_strength
);
  localparam int PA_W = $clog2(PA_DEPTH);

  sagc_phase_e      phase_reg;
  logic             sclk_prev_reg;
  logic             csn_prev_reg;
  logic [2:0]       bit_cnt_reg;
  logic [7:0]       shift_in_reg;
  logic [7:0]       shift_out_reg;
  logic             hdr_read_reg;
  logic             hdr_burst_reg;
  logic [5:0]       hdr_addr_reg;
  logic [PA_W-1:0]  pa_idx_reg;
  logic [7:0]       pa_table [PA_DEPTH];
  logic [7:0]       output_pin2_config;
  logic [7:0]       output_pin1_config;
  logic [7:0]       output_pin0_config;
  logic [7:0]       xdiv_cnt_reg;
  logic             crystal_clock;

  // ---------------------------------------------------------------
  // Edge and byte decode
  // ---------------------------------------------------------------
  wire        cs_active  = !csn_pin;
  wire        cs_start   = cs_active && csn_prev_reg;
  wire        sclk_rise  = cs_active && sclk_pin && !sclk_prev_reg;
  wire        sclk_fall  = cs_active && !sclk_pin && sclk_prev_reg;
  wire        byte_done  = sclk_rise && (bit_cnt_reg == 3'd7);
  wire [7:0]  byte_in    = {shift_in_reg[6:0], mosi_pin};
  wire        in_header  = (phase_reg == SAGC_HEADER);
  wire        in_data    = (phase_reg == SAGC_DATA);
  wire        new_read   = byte_in[HDR_RW_BIT];
  wire        new_burst  = byte_in[HDR_BURST_BIT];
  wire [5:0]  new_addr   = byte_in[5:0];
  wire        hdr_taken  = byte_done && in_header;
  wire        data_taken = byte_done && in_data;

  function automatic logic is_strobe(input logic [5:0] a, input logic rd, input logic bu);
    is_strobe = (a >= ADDR_STROBE_LO) && (a <= ADDR_STROBE_HI) && !(rd && bu);
  endfunction : is_strobe

  function automatic logic strobe_defined(input logic [5:0] a);
    strobe_defined = (a != 6'h37) && (a != 6'h38) && (a != 6'h3C);
  endfunction : strobe_defined

  // Read value for an address; strobes and reserved slots read as zero
  function automatic logic [7:0] read_value(input logic [5:0] a, input logic bu,
                                            input logic [PA_W-1:0] pi);
    read_value = 8'h00;
    if (a == ADDR_PIN2_CFG)      read_value = output_pin2_config;
    else if (a == ADDR_PIN1_CFG) read_value = output_pin1_config;
    else if (a == ADDR_PIN0_CFG) read_value = output_pin0_config;
    else if (a == ADDR_PA_TABLE) read_value = pa_table[pi];
    else if (a == ADDR_FIFO)     read_value = rx_head_data;
    else if (bu) begin
      case (a)
        ADDR_PART_ID:  read_value = PART_ID;
        ADDR_REVISION: read_value = REVISION;
        ADDR_FREQ_EST: read_value = freq_offset;
        ADDR_CHECKSUM: read_value = checksum_status;
        ADDR_SIG_STR:  read_value = signal_level;
        ADDR_RADIO_ST: read_value = radio_state;
        ADDR_PKT_STAT: read_value = packet_status;
        ADDR_TX_FILL:  read_value = {tx_underflow, tx_count};
        ADDR_RX_FILL:  read_value = {rx_overflow, rx_count};
        default:       read_value = 8'h00;
      endcase
    end
  endfunction : read_value

  // Sources come in as arguments so the pin wires follow every source change
  function automatic logic pin_level(input logic [7:0] cfg, input logic xclk,
                                     input logic rdy, input logic [63:0] src);
    logic [5:0] sel;
    logic       raw;
    sel = cfg[CFG_SEL_MSB:0];
    if (sel == SEL_CHIP_READY)       raw = rdy;
    else if (sel == SEL_CRYSTAL_DIV) raw = xclk;
    else                             raw = src[sel];
    pin_level = raw ^ cfg[CFG_INVERT_BIT];
  endfunction : pin_level

  // Address used for the next data byte of a burst
  wire        next_addr_step = hdr_burst_reg && (hdr_addr_reg < ADDR_STROBE_LO);
  wire [5:0]  data_addr      = hdr_addr_reg;
  wire        cfg_write      = data_taken && !hdr_read_reg && (data_addr <= ADDR_PIN0_CFG);
  wire        pa_access      = data_taken && (data_addr == ADDR_PA_TABLE);
  wire [PA_W-1:0] pa_idx_inc = pa_idx_reg + 1'b1;
  wire [5:0]  addr_inc       = next_addr_step ? hdr_addr_reg + 6'd1 : hdr_addr_reg;
  wire        first_read     = hdr_taken && new_read && !is_strobe(new_addr, new_read, new_burst);
  wire        more_read      = data_taken && hdr_read_reg && hdr_burst_reg;
  wire [PA_W-1:0] rd_pa_idx  = (data_addr == ADDR_PA_TABLE) ? pa_idx_inc : pa_idx_reg;
  wire [7:0]  rd_first       = read_value(new_addr, new_burst, pa_idx_reg);
  wire [7:0]  rd_more        = read_value(addr_inc, hdr_burst_reg, rd_pa_idx);
  wire        rd_fifo_first  = first_read && (new_addr == ADDR_FIFO);
  wire        rd_fifo_more   = more_read && (data_addr == ADDR_FIFO);

  // ---------------------------------------------------------------
  // Serial framing
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg     <= SAGC_IDLE;
      sclk_prev_reg <= 1'b0;
      csn_prev_reg  <= 1'b1;
      bit_cnt_reg   <= 3'd0;
      shift_in_reg  <= 8'h00;
      hdr_read_reg  <= 1'b0;
      hdr_burst_reg <= 1'b0;
      hdr_addr_reg  <= 6'h00;
    end else begin
      sclk_prev_reg <= sclk_pin;
      csn_prev_reg  <= csn_pin;
      if (!cs_active) begin
        phase_reg   <= SAGC_IDLE;
        bit_cnt_reg <= 3'd0;
      end else if (cs_start) begin
        phase_reg   <= SAGC_HEADER;
        bit_cnt_reg <= 3'd0;
      end else if (sclk_rise) begin
        bit_cnt_reg  <= bit_cnt_reg + 3'd1;
        shift_in_reg <= byte_in;
      end
      if (hdr_taken) begin
        hdr_read_reg  <= new_read;
        hdr_burst_reg <= new_burst;
        hdr_addr_reg  <= new_addr;
        phase_reg     <= is_strobe(new_addr, new_read, new_burst) ? SAGC_DONE : SAGC_DATA;
      end else if (data_taken) begin
        hdr_addr_reg <= addr_inc;
        if (!hdr_burst_reg) begin
          phase_reg <= SAGC_DONE;
        end
      end
    end
  end

  // Serial output: status byte first, then read data
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      shift_out_reg <= 8'h00;
      miso_out      <= 1'b0;
      miso_oe       <= 1'b0;
    end else begin
      miso_oe <= cs_active;
      if (cs_start) begin
        miso_out      <= chip_status[7];
        shift_out_reg <= {chip_status[6:0], 1'b0};
      end else if (first_read) begin
        shift_out_reg <= rd_first;
      end else if (more_read) begin
        shift_out_reg <= rd_more;
      end else if (byte_done) begin
        shift_out_reg <= 8'h00;
      end else if (sclk_fall) begin
        miso_out      <= shift_out_reg[7];
        shift_out_reg <= {shift_out_reg[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // Strobes, FIFO port and power table
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      strobe_pulse <= 1'b0;
      strobe_code  <= 6'h00;
      tx_wr_valid  <= 1'b0;
      tx_wr_data   <= 8'h00;
      rx_rd_pulse  <= 1'b0;
      pa_idx_reg   <= '0;
    end else begin
      strobe_pulse <= hdr_taken && is_strobe(new_addr, new_read, new_burst)
                      && strobe_defined(new_addr);
      if (hdr_taken) begin
        strobe_code <= new_addr;
      end
      tx_wr_valid <= data_taken && !hdr_read_reg && (data_addr == ADDR_FIFO);
      if (data_taken) begin
        tx_wr_data <= byte_in;
      end
      rx_rd_pulse <= rd_fifo_first || rd_fifo_more;
      if (!cs_active) begin
        pa_idx_reg <= '0;
      end else if (pa_access) begin
        pa_idx_reg <= pa_idx_inc;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (pa_access && !hdr_read_reg) begin
      pa_table[pa_idx_reg] <= byte_in;
    end
  end

  // ---------------------------------------------------------------
  // Pin configuration registers
  // ---------------------------------------------------------------
  // Only nrst clears these; sleep leaves them untouched
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      output_pin2_config <= PIN2_CFG_RESET;
      output_pin1_config <= PIN1_CFG_RESET;
      output_pin0_config <= PIN0_CFG_RESET;
    end else if (cfg_write) begin
      case (data_addr)
        ADDR_PIN2_CFG: output_pin2_config <= byte_in & PIN2_CFG_WMASK;
        ADDR_PIN1_CFG: output_pin1_config <= byte_in;
        ADDR_PIN0_CFG: output_pin0_config <= byte_in;
        default:       output_pin0_config <= output_pin0_config;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Crystal clock divider and pin drivers
  // ---------------------------------------------------------------
  wire xdiv_wrap = (xdiv_cnt_reg == 8'(CRYSTAL_HALF - 1));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xdiv_cnt_reg  <= 8'h00;
      crystal_clock <= 1'b0;
    end else begin
      xdiv_cnt_reg <= xdiv_wrap ? 8'h00 : xdiv_cnt_reg + 8'h01;
      if (xdiv_wrap) begin
        crystal_clock <= !crystal_clock;
      end
    end
  end

  wire pin2_lvl = pin_level(output_pin2_config, crystal_clock, chip_ready_low, pin_sources);
  wire pin1_lvl = pin_level(output_pin1_config, crystal_clock, chip_ready_low, pin_sources);
  wire pin0_lvl = pin_level(output_pin0_config, crystal_clock, chip_ready_low, pin_sources);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin2_out              <= 1'b0;
      pin2_oe               <= 1'b0;
      pin1_out              <= 1'b0;
      pin1_oe               <= 1'b0;
      pin0_out              <= 1'b0;
      pin0_oe               <= 1'b0;
      output_drive_strength <= 1'b0;
    end else begin
      pin2_out              <= pin2_lvl;
      pin2_oe               <= output_pin2_config[CFG_SEL_MSB:0] != SEL_THREE_STATE;
      pin1_out              <= pin1_lvl;
      pin1_oe               <= output_pin1_config[CFG_SEL_MSB:0] != SEL_THREE_STATE;
      pin0_out              <= pin0_lvl;
      pin0_oe               <= output_pin0_config[CFG_SEL_MSB:0] != SEL_THREE_STATE;
      output_drive_strength <= output_pin1_config[CFG_DRIVE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic after_rst_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) after_rst_reg <= 1'b1;
    else       after_rst_reg <= 1'b0;
  end

  AST_STROBE_RANGE: assert property (@(posedge ref_clk) disable iff (!nrst)
    strobe_pulse |-> strobe_code >= ADDR_STROBE_LO && strobe_code <= ADDR_STROBE_HI
                     && !($past(new_read) && $past(new_burst)))
    else $error("strobe outside strobe range or on burst read");
  AST_HDR_DECODE: assert property (@(posedge ref_clk) disable iff (!nrst)
    hdr_taken |=> hdr_read_reg == $past(byte_in[7]) && hdr_burst_reg == $past(byte_in[6]))
    else $error("header access type misdecoded");
  AST_SLEEP_KEEP: assert property (@(posedge ref_clk) disable iff (!nrst)
    sleep_active && !cfg_write |=> $stable(output_pin2_config) && $stable(output_pin1_config))
    else $error("pin config changed without a write");
  AST_INVERT: assert property (@(posedge ref_clk) disable iff (!nrst)
    output_pin2_config[CFG_SEL_MSB:0] != SEL_CHIP_READY
      && output_pin2_config[CFG_SEL_MSB:0] != SEL_CRYSTAL_DIV |=>
      pin2_out == (pin_sources[$past(output_pin2_config[CFG_SEL_MSB:0])]
                   ^ $past(output_pin2_config[CFG_INVERT_BIT])))
    else $error("pin2 level not inverted as configured");
  AST_PIN2_RESET: assert property (@(posedge ref_clk) disable iff (!nrst)
    after_rst_reg |-> output_pin2_config == PIN2_CFG_RESET && output_pin2_config[7] == 1'b0)
    else $error("pin2 config reset value wrong");
  AST_DRIVE: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(output_pin1_config[7]) |=> output_drive_strength == $past(output_pin1_config[7]))
    else $error("drive strength does not follow pin1 bit 7");
  AST_PIN1_TRI: assert property (@(posedge ref_clk) disable iff (!nrst)
    after_rst_reg |-> output_pin1_config == PIN1_CFG_RESET ##1 !pin1_oe)
    else $error("pin1 not three-state after reset");
  AST_XDIV: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(crystal_clock) |-> ##96 $changed(crystal_clock))
    else $error("crystal clock divider period wrong");
  AST_TX_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
    tx_wr_valid |-> !hdr_read_reg && $past(data_addr) == ADDR_FIFO)
    else $error("transmit write from wrong access");
  AST_TX_FILL: assert property (@(posedge ref_clk) disable iff (!nrst)
    first_read && new_addr == ADDR_TX_FILL && new_burst |=>
      shift_out_reg == {$past(tx_underflow), $past(tx_count)})
    else $error("transmit fill count readout wrong");
endmodule : sagc_top

// File: verif/sagc_host.sv
/*
  Host model: serial master that frames bytes for the configuration block.
  Assumes mode 0 framing, MSB first, each serial clock phase 4 ref_clk cycles.
*/
`timescale 1ns/1ps
module sagc_host (
  input  wire logic ref_clk,
  output logic      csn_pin,
  output logic      sclk_pin,
  output logic      mosi_pin,
  input  wire logic miso_out
);
  // ---------------------------------------------------------------
  // Transfer buffers and frame task
  // ---------------------------------------------------------------
  localparam int HALF = 4;
  logic [7:0] tx_buf [16];
  logic [7:0] rx_buf [16];

  initial begin
    csn_pin  = 1'b1;
    sclk_pin = 1'b0;
    mosi_pin = 1'b0;
  end

  task automatic xfer(input int n);
    @(negedge ref_clk);
    csn_pin = 1'b0;
    repeat (HALF) @(negedge ref_clk);
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        mosi_pin = tx_buf[b][i];
        repeat (HALF) @(negedge ref_clk);
        rx_buf[b][i] = miso_out;
        sclk_pin     = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        sclk_pin = 1'b0;
      end
    end
    repeat (HALF) @(negedge ref_clk);
    csn_pin = 1'b1;
    // Released data line must not keep looking valid
    mosi_pin = ~mosi_pin;
    repeat (HALF) @(negedge ref_clk);
  endtask : xfer
endmodule : sagc_host

// File: verif/tb.sv
/*
  Self-checking bench for the address map and output-pin configuration block.
  Assumes the host model in sagc_host and the sagc_pkg constants.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb
  import sagc_pkg::*;
;
  localparam logic [7:0] ID_PART = 8'hA5; // Arbitrary identity value
  localparam logic [7:0] ID_REV  = 8'h07; // Arbitrary identity value
  logic ref_clk = 1'b0, nrst = 1'b0, csn_pin, sclk_pin, mosi_pin;
  logic miso_out, miso_oe, strobe_pulse, tx_wr_valid, rx_rd_pulse;
  logic [5:0] strobe_code, last_code;
  logic [7:0] tx_wr_data, tx_last, rx_head_data = 8'h9C, chip_status = 8'h0F;
  logic sleep_active = 1'b0, chip_ready_low = 1'b1, output_drive_strength;
  logic pin2_out, pin2_oe, pin1_out, pin1_oe, pin0_out, pin0_oe;
  logic [63:0] pin_sources = 64'h0123_4567_89AB_CDE1;
  logic [6:0] tx_count = 7'h05, rx_count = 7'h3F;
  logic tx_underflow = 1'b1, rx_overflow = 1'b0;
  logic [7:0] st_exp [9];
  logic [5:0] st_addr [9];
  logic [5:0] strobes [11];
  int total_checks = 0, miscompares = 0, cycles = 0, n_strobe = 0, n_tx = 0, n_rx = 0;
  int len;

  always #25 ref_clk = ~ref_clk;

  sagc_host sagc_host_inst (.ref_clk(ref_clk), .csn_pin(csn_pin), .sclk_pin(sclk_pin),
    .mosi_pin(mosi_pin), .miso_out(miso_out));

  sagc_top #(.PART_ID(ID_PART), .REVISION(ID_REV)) sagc_top_inst (
    .ref_clk(ref_clk), .nrst(nrst), .csn_pin(csn_pin), .sclk_pin(sclk_pin),
    .mosi_pin(mosi_pin), .miso_out(miso_out), .miso_oe(miso_oe),
    .chip_status(chip_status), .freq_offset(8'h11), .checksum_status(8'h22),
    .signal_level(8'h33), .radio_state(8'h44), .packet_status(8'h55),
    .tx_count(tx_count), .tx_underflow(tx_underflow), .rx_count(rx_count),
    .rx_overflow(rx_overflow),
    .rx_head_data(rx_head_data), .sleep_active(sleep_active),
    .chip_ready_low(chip_ready_low), .pin_sources(pin_sources),
    .strobe_pulse(strobe_pulse), .strobe_code(strobe_code), .tx_wr_valid(tx_wr_valid),
    .tx_wr_data(tx_wr_data), .rx_rd_pulse(rx_rd_pulse), .pin2_out(pin2_out),
    .pin2_oe(pin2_oe), .pin1_out(pin1_out), .pin1_oe(pin1_oe), .pin0_out(pin0_out),
    .pin0_oe(pin0_oe), .output_drive_strength(output_drive_strength));

  // ---------------------------------------------------------------
  // Event monitor and hang guard
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    if (strobe_pulse === 1'b1) begin n_strobe++; last_code = strobe_code; end
    if (tx_wr_valid === 1'b1) begin n_tx++; tx_last = tx_wr_data; end
    if (rx_rd_pulse === 1'b1) n_rx++;
    if (cycles == 30000) begin miscompares++; conclude(); end
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic xf(input logic [7:0] h, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    sagc_host_inst.tx_buf[0] = h;
    sagc_host_inst.tx_buf[1] = d0;
    sagc_host_inst.tx_buf[2] = d1;
    sagc_host_inst.tx_buf[3] = 8'h00;
    n_strobe = 0; n_tx = 0; n_rx = 0;
    sagc_host_inst.xfer(n);
  endtask : xf

  task automatic cfg3(input logic [7:0] e2, input logic [7:0] e1, input logic [7:0] e0);
    xf(ACC_RD_BURST | {2'b00, ADDR_PIN2_CFG}, 8'h00, 8'h00, 4);
    `CHK(sagc_host_inst.rx_buf[0], chip_status)
    `CHK(sagc_host_inst.rx_buf[1], e2)
    `CHK(sagc_host_inst.rx_buf[2], e1)
    `CHK(sagc_host_inst.rx_buf[3], e0)
  endtask : cfg3

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    strobes = '{STROBE_CHIP_RESET, STROBE_SYNTH_ON, STROBE_OSC_OFF, STROBE_CALIBRATE,
      STROBE_RECEIVE, STROBE_TRANSMIT, STROBE_GO_IDLE, STROBE_POWER_DOWN, STROBE_FLUSH_RX,
      STROBE_FLUSH_TX, STROBE_NO_OP};
    st_addr = '{ADDR_PART_ID, ADDR_REVISION, ADDR_FREQ_EST, ADDR_CHECKSUM, ADDR_SIG_STR,
      ADDR_RADIO_ST, ADDR_PKT_STAT, ADDR_TX_FILL, ADDR_RX_FILL};
    st_exp = '{ID_PART, ID_REV, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h85, 8'h3F};
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK(pin1_oe, 1'b0)
    `CHK(output_drive_strength, 1'b0)
    `CHK(pin2_out, chip_ready_low)
    `CHK(pin2_oe, 1'b1)
    `CHK(pin0_oe, 1'b1)
    `CHK(miso_oe, 1'b0)
    chip_ready_low = 1'b0;
    repeat (3) @(negedge ref_clk);
    `CHK(pin2_out, chip_ready_low)
    len = 0;
    begin : meas
      logic p;
      p = pin0_out;
      for (int k = 0; k < 400 && pin0_out === p; k++) @(negedge ref_clk);
      p = pin0_out;
      while (len < 400 && pin0_out === p) begin @(negedge ref_clk); len++; end
    end
    `CHK(len, CRYSTAL_HALF)
    cfg3(PIN2_CFG_RESET, PIN1_CFG_RESET, PIN0_CFG_RESET);
    xf(ACC_WR_SINGLE | {2'b00, ADDR_PIN0_CFG}, 8'h45, 8'h00, 2);
    `CHK(pin0_out, ~pin_sources[5])
    xf(ACC_WR_SINGLE | {2'b00, ADDR_PIN2_CFG}, 8'hC0, 8'h00, 2);
    `CHK(pin2_out, ~pin_sources[0])
    xf(ACC_WR_SINGLE | {2'b00, ADDR_PIN1_CFG}, 8'h80, 8'h7F, 3);
    `CHK(output_drive_strength, 1'b1)
    `CHK(pin1_oe, 1'b1)
    `CHK(pin1_out, pin_sources[0])
    sleep_active = 1'b1;
    repeat (5) @(negedge ref_clk);
    cfg3(8'h40, 8'h80, 8'h45);
    sleep_active = 1'b0;
    for (int i = 0; i < 11; i++) begin
      for (int r = 0; r < 2; r++) begin
        xf((r == 0 ? ACC_WR_SINGLE : ACC_RD_SINGLE) | {2'b00, strobes[i]}, 8'h00, 8'h00, 1);
        `CHK(n_strobe, 1)
        `CHK(last_code, strobes[i])
      end
    end
    xf(ACC_WR_SINGLE | 8'h37, 8'h00, 8'h00, 1);
    `CHK(n_strobe, 0)
    for (int i = 0; i < 9; i++) begin
      xf(ACC_RD_BURST | {2'b00, st_addr[i]}, 8'h00, 8'h00, 2);
      `CHK(sagc_host_inst.rx_buf[1], st_exp[i])
      `CHK(n_strobe, 0)
    end
    tx_underflow = 1'b0;
    tx_count = 7'h40;
    rx_overflow = 1'b1;
    rx_count = 7'h12;
    xf(ACC_RD_BURST | {2'b00, ADDR_TX_FILL}, 8'h00, 8'h00, 2);
    `CHK(sagc_host_inst.rx_buf[1], 8'h40)
    xf(ACC_RD_BURST | {2'b00, ADDR_RX_FILL}, 8'h00, 8'h00, 2);
    `CHK(sagc_host_inst.rx_buf[1], 8'h92)
    xf(ACC_WR_BURST | {2'b00, ADDR_PA_TABLE}, 8'hC3, 8'h5A, 3);
    xf(ACC_RD_BURST | {2'b00, ADDR_PA_TABLE}, 8'h00, 8'h00, 3);
    `CHK(sagc_host_inst.rx_buf[1], 8'hC3)
    `CHK(sagc_host_inst.rx_buf[2], 8'h5A)
    xf(ACC_RD_SINGLE | {2'b00, ADDR_PA_TABLE}, 8'h00, 8'h00, 2);
    `CHK(sagc_host_inst.rx_buf[1], 8'hC3)
    xf(ACC_WR_BURST | {2'b00, ADDR_FIFO}, 8'h12, 8'hE7, 3);
    `CHK(n_tx, 2)
    `CHK(tx_last, 8'hE7)
    xf(ACC_RD_SINGLE | {2'b00, ADDR_FIFO}, 8'h00, 8'h00, 2);
    `CHK(sagc_host_inst.rx_buf[1], rx_head_data)
    `CHK(n_rx, 1)
    `CHK(n_tx, 0)
    conclude();
  end
endmodule : tb
